// ---- design/tca_core.sv ----
`timescale 1ns/1ps
module tca_core
  import tca_pkg::*;
#(
  parameter int DELAY_CYC = TCA_DELAY_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status toward link logic
  output logic authenticated,
  output logic write_commit,
  output logic delay_busy
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    tca_fsm_type fsm;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic lrm_mode;
    logic auth;
    logic pend_first;
    logic pend_genuine;
    logic [2:0] pend_key;
    logic [15:0] fail_cnt;
    logic [15:0] limit;
    logic [15:0] decr;
    logic [7:0] consec;
    logic [7:0] consec_lim;
    logic [TCA_NKEYS-1:0] blocked;
    logic [7:0] fsc;
    logic [7:0] fsd;
    logic chaining;
    logic chain_write;
    logic [15:0] chain_len;
    logic [7:0] atom_fill;
    logic commit;
    logic [15:0] cctr;
    logic [7:0] delay_total;
    logic [7:0] delay_left;
    logic [31:0] delay_cnt;
    logic busy;
    logic [7:0] resp_left;
    logic [7:0] last_len;
    tca_rc_type rc;
  } tca_state_type;

  tca_state_type s_r, s_nxt;

  logic access;
  logic [7:0] flen;
  logic [7:0] cap;
  logic [2:0] key;
  logic genuine;
  logic cmd_wr;
  logic no_delay;
  logic [3:0] op;
  logic [8:0] fill_sum;
  assign access = psel && penable && !s_r.ready;
  assign cap = pwdata[15:8];
  assign key = pwdata[18:16];
  assign genuine = pwdata[19];
  assign flen = pwdata[15:8];
  assign op = pwdata[3:0];
  assign cmd_wr = access && pwrite && paddr == TCA_CMD_OFF;
  assign no_delay = (s_r.delay_left == 8'h0) && (s_r.delay_cnt == 32'h0);
  // nine bits so a long frame cannot wrap the atom fill
  assign fill_sum = {1'b0, s_r.atom_fill} + {1'b0, flen};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.commit = 1'b0;
    // slow-down timer: one delay answer per DELAY_CYC
    if (s_r.delay_cnt != 32'h0) begin
      s_nxt.delay_cnt = s_r.delay_cnt - 32'h1;
    end
    if (access) begin
      s_nxt.ready = 1'b1;
      s_nxt.rdata = 32'h0;
      if (pwrite) begin
        if (paddr == TCA_CTRL_OFF) begin
          s_nxt.consec_lim = pwdata[7:0];
          s_nxt.fsd = pwdata[15:8];
          s_nxt.fsc = pwdata[23:16];
        end else if (paddr == TCA_LIMIT_OFF) begin
          s_nxt.limit = pwdata[15:0];
          s_nxt.decr = pwdata[31:16];
        end else if (paddr == TCA_CMD_OFF) begin
          case (tca_op_type'(pwdata[3:0]))
            TCA_OP_AUTH_FIRST, TCA_OP_AUTH_NEXT: begin
              if (s_r.delay_left != 8'h0 || s_r.delay_cnt != 32'h0) begin
                s_nxt.rc = TCA_RC_DELAY;
                if (s_r.delay_cnt == 32'h0) begin
                  s_nxt.delay_cnt = 32'(DELAY_CYC);
                  s_nxt.delay_left = s_r.delay_left - 8'h1;
                end
              end else if (s_r.blocked[key] && !genuine) begin
                s_nxt.rc = TCA_RC_BLOCKED;
              end else if (pwdata[3:0] == TCA_OP_AUTH_NEXT && !s_r.auth && !genuine) begin
                s_nxt.rc = TCA_RC_DENIED;
              end else if (pwdata[3:0] == TCA_OP_AUTH_FIRST && cap[TCA_MODE_BIT] == 1'b0
                           && s_r.lrm_mode && !genuine) begin
                s_nxt.rc = TCA_RC_DENIED;
              end else begin
                s_nxt.rc = TCA_RC_MORE;
                s_nxt.last_len = (genuine || (s_r.lrm_mode &&
                                 (cap[TCA_MODE_BIT] || pwdata[3:0] == TCA_OP_AUTH_NEXT)))
                                 ? TCA_LEN_LRM : TCA_LEN_AES;
                s_nxt.pend_first = (pwdata[3:0] == TCA_OP_AUTH_FIRST);
                s_nxt.pend_genuine = genuine;
                s_nxt.pend_key = key;
              end
            end
            TCA_OP_AUTH_OK: begin
              s_nxt.auth = 1'b1;
              s_nxt.rc = TCA_RC_OK;
              s_nxt.consec = 8'h0;
              s_nxt.delay_total = 8'h0;
              s_nxt.delay_left = 8'h0;
              if (s_r.pend_first) begin
                s_nxt.cctr = 16'h0;
              end
              if (!s_r.lrm_mode) begin
                s_nxt.fail_cnt = (s_r.fail_cnt > s_r.decr) ?
                                 s_r.fail_cnt - s_r.decr : 16'h0;
              end
            end
            TCA_OP_AUTH_BAD: begin
              s_nxt.rc = TCA_RC_INTEGRITY;
              s_nxt.auth = 1'b0;
              if (s_r.fail_cnt != TCA_CCTR_MAX) begin
                s_nxt.fail_cnt = s_r.fail_cnt + 16'h1;
              end
              if (s_r.fail_cnt + 16'h1 >= s_r.limit && !s_r.pend_genuine) begin
                s_nxt.blocked[s_r.pend_key] = 1'b1;
              end
              if (s_r.consec != 8'hFF) begin
                s_nxt.consec = s_r.consec + 8'h1;
              end
              if (s_r.consec + 8'h1 >= s_r.consec_lim) begin
                // each failure from the consec_lim-th consecutive one on raises the total delay, capped
                if (s_r.delay_total < TCA_DELAY_MAX) begin
                  s_nxt.delay_total = s_r.delay_total + TCA_DELAY_STEP;
                end
                s_nxt.delay_left = (s_r.delay_total < TCA_DELAY_MAX) ?
                                   s_r.delay_total + TCA_DELAY_STEP : TCA_DELAY_MAX;
              end
            end
            TCA_OP_KEY_CHANGE: begin
              if (s_r.auth && s_r.pend_key == TCA_MASTER_KEY
                  && !s_r.blocked[TCA_MASTER_KEY] && key != TCA_MASTER_KEY) begin
                s_nxt.blocked[key] = 1'b0;
                s_nxt.rc = TCA_RC_OK;
              end else begin
                s_nxt.rc = TCA_RC_DENIED;
              end
            end
            TCA_OP_ENABLE_LRM: begin
              s_nxt.lrm_mode = 1'b1;
              s_nxt.rc = TCA_RC_OK;
            end
            default: begin
              s_nxt.rc = s_r.rc;
            end
          endcase
        end else if (paddr == TCA_FRAME_OFF) begin
          // bit0 more-follows, bit1 write, 15:8 frame length
          if (!s_r.chaining && flen > s_r.fsc) begin
            s_nxt.rc = TCA_RC_LENGTH;
          end else begin
            s_nxt.rc = pwdata[0] ? TCA_RC_MORE : TCA_RC_OK;
            s_nxt.chaining = pwdata[0];
            s_nxt.chain_write = pwdata[1];
            s_nxt.chain_len = s_r.chaining ? s_r.chain_len + 16'(flen) : 16'(flen);
            // writes commit per atom as data arrives, not after the chain
            if (pwdata[1]) begin
              if (fill_sum >= {1'b0, TCA_ATOM_BYTES}) begin
                s_nxt.commit = 1'b1;
                s_nxt.atom_fill = 8'(fill_sum - {1'b0, TCA_ATOM_BYTES});
              end else begin
                s_nxt.atom_fill = fill_sum[7:0];
              end
            end
            if (!pwdata[0]) begin
              if (pwdata[1] && s_nxt.atom_fill != 8'h0) begin
                s_nxt.commit = 1'b1;
              end
              s_nxt.atom_fill = 8'h0;
              if (s_r.auth) begin
                if (s_r.cctr == TCA_CCTR_MAX) begin
                  s_nxt.rc = TCA_RC_INTEGRITY;
                  s_nxt.auth = 1'b0;
                end else begin
                  s_nxt.cctr = s_r.cctr + 16'h1;
                end
              end
            end
          end
        end else if (paddr == TCA_RESP_OFF) begin
          s_nxt.resp_left = pwdata[7:0];
        end else begin
          s_nxt.err = 1'b1;
        end
      end else begin
        if (paddr == TCA_CTRL_OFF) begin
          s_nxt.rdata = {8'h0, s_r.fsc, s_r.fsd, s_r.consec_lim};
        end else if (paddr == TCA_STAT_OFF) begin
          s_nxt.rdata = {s_r.last_len, 8'h0, 6'h0, s_r.lrm_mode, s_r.auth,
                         4'h0, s_r.rc};
        end else if (paddr == TCA_FAIL_OFF) begin
          s_nxt.rdata = {s_r.consec, s_r.delay_left, s_r.fail_cnt};
        end else if (paddr == TCA_LIMIT_OFF) begin
          s_nxt.rdata = {s_r.decr, s_r.limit};
        end else if (paddr == TCA_BLOCK_OFF) begin
          s_nxt.rdata = {27'h0, s_r.blocked};
        end else if (paddr == TCA_FRAME_OFF) begin
          s_nxt.rdata = {s_r.chain_len, 8'h0, 6'h0, s_r.chain_write, s_r.chaining};
        end else if (paddr == TCA_RESP_OFF) begin
          // each read pops one frame, at most fsd bytes
          if (s_r.resp_left > s_r.fsd) begin
            s_nxt.rdata = {23'h0, 1'b1, s_r.fsd};
            s_nxt.resp_left = s_r.resp_left - s_r.fsd;
          end else begin
            s_nxt.rdata = {24'h0, s_r.resp_left};
            s_nxt.resp_left = 8'h0;
          end
        end else if (paddr == TCA_CCTR_OFF) begin
          s_nxt.rdata = {16'h0, s_r.cctr};
        end else begin
          s_nxt.err = 1'b1;
        end
      end
    end
    s_nxt.busy = (s_nxt.delay_cnt != 32'h0);
    s_nxt.fsm = s_nxt.ready ? TCA_ST_WAIT : TCA_ST_IDLE;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // fail state is volatile here; real parts map it to nonvolatile cells
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.limit <= TCA_LIMIT_RST;
      s_r.decr <= TCA_DECR_RST;
      s_r.consec_lim <= TCA_CONSEC_RST;
      s_r.fsc <= TCA_BUF_RST;
      s_r.fsd <= TCA_BUF_RST;
      s_r.rc <= TCA_RC_OK;
      s_r.fsm <= TCA_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a bare state bit, so no decode glitches reach the link
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign authenticated = s_r.auth;
  assign write_commit = s_r.commit;
  assign delay_busy = s_r.busy;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  lrm_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.lrm_mode |=> s_r.lrm_mode) else $error("resilient mode dropped");
  aes_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == TCA_CMD_OFF && pwdata[3:0] == TCA_OP_AUTH_FIRST
    && s_r.lrm_mode && cap == TCA_CAP_AES && !genuine && !s_r.blocked[key]
    && s_r.delay_left == 8'h0 && s_r.delay_cnt == 32'h0
    |=> s_r.rc == TCA_RC_DENIED) else $error("aes not rejected");
  next_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == TCA_CMD_OFF && pwdata[3:0] == TCA_OP_AUTH_NEXT
    && !s_r.auth |=> s_r.rc != TCA_RC_MORE || s_r.pend_genuine)
    else $error("followup accepted unauthenticated");
  resp_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.rc == TCA_RC_MORE && !s_r.lrm_mode && !s_r.pend_genuine && !s_r.chaining
    |-> s_r.last_len == TCA_LEN_AES) else $error("aes answer length");
  fail_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == TCA_CMD_OFF && pwdata[3:0] == TCA_OP_AUTH_BAD
    && s_r.fail_cnt != TCA_CCTR_MAX |=> s_r.fail_cnt == $past(s_r.fail_cnt) + 16'h1)
    else $error("fail count not raised");
  master_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.blocked[0] |=> s_r.blocked[0]) else $error("master key unblocked");
  cctr_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.chaining |=> s_r.cctr == $past(s_r.cctr) || !s_r.chaining)
    else $error("counter moved mid chain");
  delay_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(delay_busy) |-> delay_busy [*8]) else $error("delay too short");
  frame_fit_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && paddr == TCA_RESP_OFF |=> s_r.rdata[7:0] <= s_r.fsd)
    else $error("frame above reader size");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable ##1 psel && penable |=> pready) else $error("late ready");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held too long");
  slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  commit_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    write_commit |=> !write_commit) else $error("commit held");
  first_any_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && op == TCA_OP_AUTH_FIRST && no_delay && !genuine && !s_r.blocked[key]
    && (cap[TCA_MODE_BIT] || !s_r.lrm_mode) |=> s_r.rc == TCA_RC_MORE)
    else $error("first auth refused");
  genuine_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && (op == TCA_OP_AUTH_FIRST || op == TCA_OP_AUTH_NEXT) && genuine && no_delay
    |=> s_r.rc == TCA_RC_MORE) else $error("genuine auth refused");
  lrm_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && op == TCA_OP_AUTH_FIRST && no_delay && !genuine && !s_r.blocked[key]
    && s_r.lrm_mode && cap == TCA_CAP_LRM |=> s_r.last_len == TCA_LEN_LRM)
    else $error("resilient answer length");
  delay_rc_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && (op == TCA_OP_AUTH_FIRST || op == TCA_OP_AUTH_NEXT) && !no_delay
    |=> s_r.rc == TCA_RC_DELAY) else $error("delay answer missing");
  speed_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && op == TCA_OP_AUTH_OK |=> s_r.delay_left == 8'h0 && s_r.consec == 8'h0)
    else $error("slow-down kept");
  decr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && op == TCA_OP_AUTH_OK && !s_r.lrm_mode && s_r.fail_cnt > s_r.decr
    |=> s_r.fail_cnt == $past(s_r.fail_cnt) - $past(s_r.decr))
    else $error("fail count not lowered");

  auth_ok_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_r.auth));
  block_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(|s_r.blocked));
  delay_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(delay_busy));
  commit_c: cover property (@(posedge pclk) disable iff (!presetn) s_r.commit && s_r.chaining);
  lrm_on_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_r.lrm_mode));

endmodule

// ---- design/tca_pkg.sv ----
package tca_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] TCA_CTRL_OFF = 8'h00;
  localparam logic [7:0] TCA_CMD_OFF = 8'h04;
  localparam logic [7:0] TCA_STAT_OFF = 8'h08;
  localparam logic [7:0] TCA_FAIL_OFF = 8'h0C;
  localparam logic [7:0] TCA_LIMIT_OFF = 8'h10;
  localparam logic [7:0] TCA_BLOCK_OFF = 8'h14;
  localparam logic [7:0] TCA_FRAME_OFF = 8'h18;
  localparam logic [7:0] TCA_RESP_OFF = 8'h1C;
  localparam logic [7:0] TCA_CCTR_OFF = 8'h20;

  // ----------------------------------------
  // fields and values
  // ----------------------------------------
  localparam int TCA_MODE_BIT = 1;
  localparam logic [7:0] TCA_CAP_AES = 8'h00;
  localparam logic [7:0] TCA_CAP_LRM = 8'h02;
  localparam logic [7:0] TCA_LEN_AES = 8'h11;
  localparam logic [7:0] TCA_LEN_LRM = 8'h12;
  localparam logic [7:0] TCA_ATOM_BYTES = 8'h80;
  localparam logic [15:0] TCA_CCTR_MAX = 16'hFFFF;
  localparam int TCA_NKEYS = 5;
  localparam logic [2:0] TCA_MASTER_KEY = 3'h0;
  localparam logic [15:0] TCA_LIMIT_RST = 16'h03E8;
  localparam logic [15:0] TCA_DECR_RST = 16'h000A;
  localparam logic [7:0] TCA_CONSEC_RST = 8'h03;
  localparam logic [7:0] TCA_BUF_RST = 8'h40;

  // delay of one slow-down answer: 65 percent of frame waiting time
  localparam int TCA_FWT_NS = 77000;
  localparam int TCA_PCLK_NS = 25;
  localparam int TCA_DELAY_PCT = 65;
  localparam int TCA_DELAY_CYC = (TCA_FWT_NS * TCA_DELAY_PCT) / (100 * TCA_PCLK_NS);
  localparam logic [7:0] TCA_DELAY_STEP = 8'h01;
  localparam logic [7:0] TCA_DELAY_MAX = 8'h10;

  // ----------------------------------------
  // commands and answers
  // ----------------------------------------
  typedef enum logic [3:0] {
    TCA_OP_NONE = 4'h0,
    TCA_OP_AUTH_FIRST = 4'h1,
    TCA_OP_AUTH_NEXT = 4'h2,
    TCA_OP_AUTH_OK = 4'h3,
    TCA_OP_AUTH_BAD = 4'h4,
    TCA_OP_KEY_CHANGE = 4'h5,
    TCA_OP_ENABLE_LRM = 4'h6,
    TCA_OP_FRAME = 4'h7,
    TCA_OP_RESP = 4'h8
  } tca_op_type;

  typedef enum logic [3:0] {
    TCA_RC_OK = 4'h0,
    TCA_RC_MORE = 4'h1,
    TCA_RC_DENIED = 4'h2,
    TCA_RC_DELAY = 4'h3,
    TCA_RC_LENGTH = 4'h4,
    TCA_RC_BLOCKED = 4'h5,
    TCA_RC_INTEGRITY = 4'h6
  } tca_rc_type;

  typedef enum logic [1:0] {
    TCA_ST_IDLE = 2'b00,
    TCA_ST_WAIT = 2'b01
  } tca_fsm_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tca_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tca_apb_rsp_type;

endpackage

// ---- sim/tca_reader.sv ----
`timescale 1ns/1ps
module tca_reader
  import tca_pkg::*;
(
  // clock
  input wire logic pclk,
  // apb master side
  output tca_apb_req_type req,
  input wire tca_apb_rsp_type rsp
);
  logic [31:0] rdata;
  logic err;
  initial req = '0;
  // ----------------------------------------
  // bus cycle
  // ----------------------------------------
  // request held until pready is sampled high or 50 cycles pass, released at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rdata = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // ----------------------------------------
  // reader commands
  // ----------------------------------------
  task automatic cmd(input tca_op_type op, input logic [7:0] cap, input logic [2:0] key,
                     input logic gen);
    xfer(1'b1, TCA_CMD_OFF, {12'h000, gen, key, cap, 4'h0, op});
  endtask
  // three-pass exchange cut to request and verdict
  // mode asked through bit 1, aes asks with 00h
  task automatic auth(input logic lrm, input logic [2:0] key, input logic good);
    cmd(TCA_OP_AUTH_FIRST, lrm ? TCA_CAP_LRM : TCA_CAP_AES, key, 1'b0);
    cmd(good ? TCA_OP_AUTH_OK : TCA_OP_AUTH_BAD, 8'h00, key, 1'b0);
  endtask
  // once authenticated the reader renews with the followup kind
  task automatic renew(input logic [2:0] key);
    cmd(TCA_OP_AUTH_NEXT, 8'h00, key, 1'b0);
    cmd(TCA_OP_AUTH_OK, 8'h00, key, 1'b0);
  endtask
  // headers fit the tag buffer; longer ones only when a test wants a refusal
  task automatic frame(input logic more, input logic wr, input logic [7:0] len);
    xfer(1'b1, TCA_FRAME_OFF, {16'h0000, len, 6'h00, wr, more});
  endtask
endmodule

// ---- sim/test_tag_chaining_and_auth_control.sv ----
`timescale 1ns/1ps
module test_tag_chaining_and_auth_control;
  import tca_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  tca_apb_req_type req;
  wire tca_apb_rsp_type rsp;
  logic authenticated, write_commit, delay_busy;
  int mismatches, checks, commits, cyc;
  logic [31:0] v;
  initial forever #12.5 pclk = ~pclk;
  tca_reader tca_reader_inst (.pclk(pclk), .req(req), .rsp(rsp));
  // short slow-down timer keeps the run brief
  tca_core #(.DELAY_CYC(10)) tca_core_inst (.pclk(pclk), .presetn(presetn),
    .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
    .pwdata(req.pwdata), .prdata(rsp.prdata), .pready(rsp.pready), .pslverr(rsp.pslverr),
    .authenticated(authenticated), .write_commit(write_commit), .delay_busy(delay_busy));
  // ----------------------------------------
  // checking and verdict
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    tca_reader_inst.xfer(1'b0, a, 32'h0);
    v = tca_reader_inst.rdata;
  endtask
  task automatic rc_is(input string what, input tca_rc_type rc);
    rd(TCA_STAT_OFF);
    check(what, {28'h0, v[3:0]}, {28'h0, rc});
  endtask
  // size of the next response piece and its more flag
  function automatic logic [31:0] piece(input int rem, input int fsd);
    return {23'h0, rem > fsd, 8'(rem > fsd ? fsd : rem)};
  endfunction
  always @(posedge pclk) begin
    if (write_commit === 1'b1) commits++;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int rem, fsd, c0, n;
    logic [15:0] decr;
    presetn = 1'b0;
    mismatches = 0; checks = 0; commits = 0; cyc = 0;
    void'($urandom(32'hd4e84831));
    fsd = 16 + ($urandom % 49);
    decr = 16'($urandom % 3 + 1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TCA_CTRL_OFF);
    check("ctrl", v, {8'h00, TCA_BUF_RST, TCA_BUF_RST, TCA_CONSEC_RST});
    rd(TCA_LIMIT_OFF);
    check("limit", v, {TCA_DECR_RST, TCA_LIMIT_RST});
    rd(8'h30);
    check("unmapped", {v[30:0], tca_reader_inst.err}, 32'h1);
    tca_reader_inst.cmd(TCA_OP_AUTH_NEXT, TCA_CAP_AES, 3'h1, 1'b0);
    rc_is("followup unauth", TCA_RC_DENIED);
    tca_reader_inst.cmd(TCA_OP_AUTH_NEXT, TCA_CAP_LRM, 3'h1, 1'b1);
    rd(TCA_STAT_OFF);
    check("genuine", {31'h0, v[3:0] == TCA_RC_DENIED}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      tca_reader_inst.cmd(TCA_OP_AUTH_FIRST, i ? TCA_CAP_LRM : TCA_CAP_AES, 3'h0, 1'b0);
      rd(TCA_STAT_OFF);
      check("aes answer len", {24'h0, v[31:24]}, {24'h0, TCA_LEN_AES});
    end
    tca_reader_inst.cmd(TCA_OP_AUTH_OK, 8'h00, 3'h0, 1'b0);
    check("authed", {31'h0, authenticated}, 32'h1);
    tca_reader_inst.renew(3'h0);
    check("renewed", {31'h0, authenticated}, 32'h1);
    tca_reader_inst.xfer(1'b1, TCA_CTRL_OFF, {8'h00, TCA_BUF_RST, 8'(fsd), 8'hFF});
    tca_reader_inst.frame(1'b1, 1'b1, 8'h41);
    rc_is("long header", TCA_RC_LENGTH);
    rd(TCA_CCTR_OFF);
    c0 = int'(v[15:0]);
    commits = 0;
    tca_reader_inst.frame(1'b1, 1'b1, 8'h40);
    tca_reader_inst.frame(1'b1, 1'b1, 8'h40);
    rd(TCA_FRAME_OFF);
    check("chaining", {30'h0, v[1:0]}, 32'h3);
    check("early commit", 32'(commits), 32'h1);
    tca_reader_inst.frame(1'b0, 1'b1, 8'h20);
    repeat (2) @(posedge pclk);
    check("tail commit", 32'(commits), 32'h2);
    rd(TCA_CCTR_OFF);
    check("cctr once", {16'h0, v[15:0]}, 32'(c0 + 1));
    rem = 1 + ($urandom % 255);
    tca_reader_inst.xfer(1'b1, TCA_RESP_OFF, {24'h0, 8'(rem)});
    while (rem > 0) begin
      rd(TCA_RESP_OFF);
      check("resp piece", {23'h0, v[8:0]}, piece(rem, fsd));
      rem = rem - fsd;
    end
    tca_reader_inst.xfer(1'b1, TCA_LIMIT_OFF, {decr, 16'h0003});
    repeat (3) tca_reader_inst.auth(1'b0, 3'h1, 1'b0);
    rd(TCA_FAIL_OFF);
    check("fail count", {16'h0, v[15:0]}, 32'h3);
    rd(TCA_BLOCK_OFF);
    check("blocked", {27'h0, v[4:0]}, 32'h2);
    tca_reader_inst.cmd(TCA_OP_AUTH_FIRST, TCA_CAP_AES, 3'h1, 1'b0);
    rc_is("blocked key", TCA_RC_BLOCKED);
    tca_reader_inst.auth(1'b0, 3'h0, 1'b1);
    rd(TCA_FAIL_OFF);
    check("decrement", {16'h0, v[15:0]}, 32'(3 - decr));
    tca_reader_inst.cmd(TCA_OP_KEY_CHANGE, 8'h00, 3'h1, 1'b0);
    rd(TCA_BLOCK_OFF);
    check("unblocked", {27'h0, v[4:0]}, 32'h0);
    tca_reader_inst.cmd(TCA_OP_ENABLE_LRM, 8'h00, 3'h0, 1'b0);
    tca_reader_inst.cmd(TCA_OP_AUTH_FIRST, TCA_CAP_AES, 3'h0, 1'b0);
    rc_is("aes refused", TCA_RC_DENIED);
    tca_reader_inst.cmd(TCA_OP_AUTH_FIRST, TCA_CAP_LRM, 3'h0, 1'b0);
    rd(TCA_STAT_OFF);
    check("lrm answer", {22'h0, v[31:24], v[9], 1'b0}, {22'h0, TCA_LEN_LRM, 2'b10});
    tca_reader_inst.xfer(1'b1, TCA_LIMIT_OFF, {decr, 16'h0100});
    tca_reader_inst.xfer(1'b1, TCA_CTRL_OFF, {8'h00, TCA_BUF_RST, 8'(fsd), 8'h02});
    repeat (3) tca_reader_inst.auth(1'b1, 3'h2, 1'b0);
    tca_reader_inst.cmd(TCA_OP_AUTH_FIRST, TCA_CAP_LRM, 3'h2, 1'b0);
    check("slow answer", {31'h0, delay_busy}, 32'h1);
    rc_is("delay rc", TCA_RC_DELAY);
    n = 0;
    do begin
      while (delay_busy === 1'b1) @(posedge pclk);
      tca_reader_inst.cmd(TCA_OP_AUTH_FIRST, TCA_CAP_LRM, 3'h2, 1'b0);
      rd(TCA_STAT_OFF);
      n++;
    end while (v[3:0] == TCA_RC_DELAY && n < 40);
    check("delay ends", {31'h0, n < 40}, 32'h1);
    tca_reader_inst.cmd(TCA_OP_AUTH_OK, 8'h00, 3'h2, 1'b0);
    rd(TCA_FAIL_OFF);
    check("speed back", {16'h0, v[31:16]}, 32'h0);
    rd(TCA_STAT_OFF);
    check("lrm kept", {31'h0, v[9]}, 32'h1);
    give_verdict();
  end
endmodule
